/* shared/bwsrc_cfg.svh */
// bwsrc_cfg.svh: register indices, reset values and field positions
// of the bus wait-state and release control bank.
// assumes: included by bare name; byte address of a register is four times its index.
`ifndef BWSRC_CFG_SVH
`define BWSRC_CFG_SVH

// register indices; byte address = index * 4
`define BWSRC_IDX_ACCESS_STATE 8'hed
`define BWSRC_IDX_WAIT_CONTROL 8'hee
`define BWSRC_IDX_WAIT_AREA_EN 8'hef
`define BWSRC_IDX_BUS_RELEASE 8'hf0
`define BWSRC_IDX_MODE_CAPTURE 8'hf1

// reset values
`define BWSRC_RST_ACCESS_STATE 8'hff
`define BWSRC_RST_WAIT_CONTROL 8'hf3
`define BWSRC_RST_WAIT_AREA_EN 8'hff
`define BWSRC_RST_BUS_RELEASE 8'hfe

// fixed read bits
`define BWSRC_WAITCTL_FIXED 8'hf0
`define BWSRC_MODECAP_FIXED 8'h80
`define BWSRC_RELCTL_FIXED 8'h1e

// writable masks
`define BWSRC_WAITCTL_WMASK 8'h0f

// field positions
`define BWSRC_WAITCTL_MODE_LSB 2
`define BWSRC_WAITCTL_CNT_LSB 0
`define BWSRC_RELCTL_EN_BIT 0
`define BWSRC_RELCTL_TOP_LSB 5

`endif

/* shared/bwsrc_pkg.sv */
// bwsrc_pkg: types shared by the wait-state bank and its cycle sequencer.
// assumes: bwsrc_cfg.svh carries all numeric constants.
package bwsrc_pkg;

   // wait mode field encodings
   typedef enum logic [1:0] {
      BWSRC_WM_PROG = 2'h0,
      BWSRC_WM_NONE = 2'h1,
      BWSRC_WM_PIN1 = 2'h2,
      BWSRC_WM_AUTO = 2'h3
   } bwsrc_wmode_t;

   // external access cycle states
   typedef enum logic [2:0] {
      BWSRC_S_IDLE,
      BWSRC_S_T1,
      BWSRC_S_T2,
      BWSRC_S_TW,
      BWSRC_S_T3
   } bwsrc_state_t;

endpackage

/* src/bwsrc_cycle_seq.sv */
// bwsrc_cycle_seq: external access cycle sequencer with wait insertion.
// assumes: start only when idle; settings are snapshotted at start.
`timescale 1ns/1ps
`include "bwsrc_cfg.svh"
module bwsrc_cycle_seq
   import bwsrc_pkg::*;
(
   input wire logic core_clk, // system clock
   input wire logic sys_rst, // async reset, active high
   input wire logic cyc_start, // one-cycle start of an access
   input wire logic [2:0] cyc_area, // area of the access
   input wire logic [7:0] area_three_state, // per-area three-state bits
   input wire logic [7:0] area_wait_enable, // per-area wait control enables
   input wire logic [1:0] wait_mode_sel, // wait mode field
   input wire logic [1:0] wait_count, // wait count field
   input wire logic ext_wait_req, // external wait request, high = wait
   output bwsrc_state_t cyc_state, // current cycle state
   output logic cyc_busy, // access in progress
   output logic cyc_done // last state of the access
);

   bwsrc_state_t state_ff;
   bwsrc_state_t nxt_state;
   logic three_ff;
   logic wen_ff;
   bwsrc_wmode_t mode_ff;
   logic [1:0] cnt_ff;
   logic [1:0] left_ff;
   logic [1:0] nxt_left;
   logic pin_ff;
   logic nxt_pin;

   // snapshot of settings, so a register write mid-cycle cannot tear it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         three_ff <= 1'b0;
         wen_ff <= 1'b0;
         mode_ff <= BWSRC_WM_PROG;
         cnt_ff <= 2'h0;
      end else if (cyc_start && state_ff == BWSRC_S_IDLE) begin
         // (RL8) area cycle length
         three_ff <= area_three_state[cyc_area];
         // (RL3) per-area enable
         wen_ff <= area_wait_enable[cyc_area];
         mode_ff <= bwsrc_wmode_t'(wait_mode_sel);
         cnt_ff <= wait_count;
      end
   end

   // next state and wait bookkeeping
   always_comb begin
      nxt_state = state_ff;
      nxt_left = left_ff;
      nxt_pin = pin_ff;
      unique case (state_ff)
         BWSRC_S_IDLE: begin
            if (cyc_start) begin
               nxt_state = BWSRC_S_T1;
            end
         end
         BWSRC_S_T1: begin
            nxt_state = BWSRC_S_T2;
         end
         BWSRC_S_T2: begin
            nxt_state = BWSRC_S_T3;
            nxt_left = 2'h0;
            nxt_pin = 1'b0;
            // (RL8) two-state area ends here
            if (!three_ff) begin
               nxt_state = BWSRC_S_IDLE;
            end else if (!wen_ff) begin
               // (RL9) pin wait mode 0
               if (ext_wait_req) begin
                  nxt_state = BWSRC_S_TW;
                  nxt_pin = 1'b1;
               end
            end else begin
               // (RL1) wait mode select
               unique case (mode_ff)
                  BWSRC_WM_PROG: begin
                     // (RL2) programmed count
                     if (cnt_ff != 2'h0) begin
                        nxt_state = BWSRC_S_TW;
                        nxt_left = cnt_ff - 2'h1;
                     end
                  end
                  BWSRC_WM_NONE: begin
                     nxt_state = BWSRC_S_T3;
                  end
                  BWSRC_WM_PIN1: begin
                     // (RL9) count then pin
                     nxt_pin = 1'b1;
                     if (cnt_ff != 2'h0) begin
                        nxt_state = BWSRC_S_TW;
                        nxt_left = cnt_ff - 2'h1;
                     end else if (ext_wait_req) begin
                        nxt_state = BWSRC_S_TW;
                     end
                  end
                  BWSRC_WM_AUTO: begin
                     // (RL9) count only on request
                     if (ext_wait_req && cnt_ff != 2'h0) begin
                        nxt_state = BWSRC_S_TW;
                        nxt_left = cnt_ff - 2'h1;
                     end
                  end
               endcase
            end
         end
         BWSRC_S_TW: begin
            if (left_ff != 2'h0) begin
               nxt_left = left_ff - 2'h1;
            end else if (!(pin_ff && ext_wait_req)) begin
               nxt_state = BWSRC_S_T3;
            end
         end
         BWSRC_S_T3: begin
            nxt_state = BWSRC_S_IDLE;
         end
      endcase
   end

   // state registers
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_ff <= BWSRC_S_IDLE;
         left_ff <= 2'h0;
         pin_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         left_ff <= nxt_left;
         pin_ff <= nxt_pin;
      end
   end

   assign cyc_state = state_ff;
   assign cyc_busy = (state_ff != BWSRC_S_IDLE);
   assign cyc_done = (state_ff == BWSRC_S_T3) || (state_ff == BWSRC_S_T2 && !three_ff);

endmodule

/* src/bwsrc_top.sv */
// bwsrc_top: bus wait-state and bus release control bank with an
// AHB-Lite register slave and the external access cycle sequencer.
// assumes: single master, word transfers only, mode pins synchronous.
//
// Contract
// (RL1) wait mode bits pick programmable, none, pin mode 1 or pin auto-wait.
// (RL2) wait count 0..3 sets inserted wait states.
// (RL3) each area enable bit turns wait control on; off means pin wait mode 0.
// (RL4) all area enable bits are one after reset.
// (RL5) mode field shows the three mode pins; codes 1..7 are modes 1..7.
// (RL6) bus release enable resets to zero; zero refuses release.
// (RL7) top address enables writable only in modes 3, 4, 6; else read one.
// (RL8) area access-state bit zero gives two states, one gives three.
// (RL9) pin modes sample wait input in three-state enabled areas, extend while held; pin auto-wait here inserts only the count and never extends.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "bwsrc_cfg.svh"
module bwsrc_top
   import bwsrc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic core_clk, // system clock, 100 MHz
   input wire logic sys_rst, // async reset, active high
   input wire logic hsel, // slave select
   input wire logic [ADDR_W-1:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // transfer size
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // response, always okay
   input wire logic [2:0] mode_pin, // operating mode pins
   input wire logic acc_req, // request for an external access
   input wire logic [2:0] acc_area, // area of the requested access
   output logic acc_ready, // access request taken this cycle
   input wire logic ext_wait_req, // external wait request, high = wait
   output bwsrc_state_t acc_state, // external cycle state
   output logic acc_busy, // external cycle in progress
   output logic acc_done, // last state of an external cycle
   input wire logic ext_bus_req, // external master asks for the bus
   output logic ext_bus_grant, // bus released to external master
   output logic [2:0] top_addr_enable // 1 = address output, 0 = port
);

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;

   logic [7:0] access_state_ff;
   logic [7:0] wait_control_ff;
   logic [7:0] wait_area_enable_ff;
   logic [7:0] bus_release_ff;
   logic [2:0] mode_pin_ff;
   logic wr_pend_ff;
   logic rd_pend_ff;
   logic [7:0] idx_ff;
   logic idx_ok_ff;
   logic addr_phase;
   logic wr_en;
   logic [7:0] wr_byte;
   logic [7:0] rd_byte;
   logic rd_wait_ff;
   logic [7:0] rd_data_ff;
   logic grant_ff;
   logic seq_start;
   logic [1:0] wait_mode_sel;
   logic [1:0] wait_count;
   logic bus_release_enable;

   // modes where the top address lines can be handed to port use
   function automatic logic addr_sel_mode(input logic [2:0] mode);
      addr_sel_mode = (mode == 3'h3) || (mode == 3'h4) || (mode == 3'h6);
   endfunction

   // register hit on the captured index
   function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
      hit = (idx == reg_idx);
   endfunction

   // reads take one wait state so read data can come from a flip-flop;
   // writes are never stalled
   assign hreadyout = !rd_wait_ff;
   assign hresp = 1'b0;
   assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

   // capture of the address phase
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         idx_ff <= 8'h00;
         idx_ok_ff <= 1'b0;
      end else if (hready) begin
         wr_pend_ff <= addr_phase && hwrite;
         rd_pend_ff <= addr_phase && !hwrite;
         idx_ff <= haddr[9:2];
         // upper address bits must be zero for a hit
         idx_ok_ff <= (haddr >> 10) == '0;
      end
   end

   assign wr_en = wr_pend_ff && idx_ok_ff;
   assign wr_byte = hwdata[7:0];

   // mode pins follow the board continuously
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_pin_ff <= 3'h0;
      end else begin
         // (RL5) mode pin levels
         mode_pin_ff <= mode_pin;
      end
   end

   // access state register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         access_state_ff <= `BWSRC_RST_ACCESS_STATE;
      end else if (wr_en && hit(idx_ff, `BWSRC_IDX_ACCESS_STATE)) begin
         access_state_ff <= wr_byte;
      end
   end

   // wait control register; upper nibble is not stored
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_control_ff <= `BWSRC_RST_WAIT_CONTROL & `BWSRC_WAITCTL_WMASK;
      end else if (wr_en && hit(idx_ff, `BWSRC_IDX_WAIT_CONTROL)) begin
         wait_control_ff <= wr_byte & `BWSRC_WAITCTL_WMASK;
      end
   end

   // area wait enable register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // (RL4) all areas enabled
         wait_area_enable_ff <= `BWSRC_RST_WAIT_AREA_EN;
      end else if (wr_en && hit(idx_ff, `BWSRC_IDX_WAIT_AREA_EN)) begin
         wait_area_enable_ff <= wr_byte;
      end
   end

   // bus release control register
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         // (RL6) release refused after reset
         bus_release_ff <= `BWSRC_RST_BUS_RELEASE;
      end else if (wr_en && hit(idx_ff, `BWSRC_IDX_BUS_RELEASE)) begin
         bus_release_ff[`BWSRC_RELCTL_EN_BIT] <= wr_byte[`BWSRC_RELCTL_EN_BIT];
         // (RL7) gated top address enables
         if (addr_sel_mode(mode_pin_ff)) begin
            bus_release_ff[7:5] <= wr_byte[7:5];
         end
      end
   end

   // read mux over the stored registers; unmapped reads return zero
   always_comb begin
      rd_byte = 8'h00;
      if (rd_pend_ff && idx_ok_ff) begin
         if (hit(idx_ff, `BWSRC_IDX_ACCESS_STATE)) begin
            rd_byte = access_state_ff;
         end else if (hit(idx_ff, `BWSRC_IDX_WAIT_CONTROL)) begin
            rd_byte = wait_control_ff | `BWSRC_WAITCTL_FIXED;
         end else if (hit(idx_ff, `BWSRC_IDX_WAIT_AREA_EN)) begin
            rd_byte = wait_area_enable_ff;
         end else if (hit(idx_ff, `BWSRC_IDX_BUS_RELEASE)) begin
            rd_byte = {top_addr_enable, 4'hf, bus_release_ff[`BWSRC_RELCTL_EN_BIT]};
         end else if (hit(idx_ff, `BWSRC_IDX_MODE_CAPTURE)) begin
            // (RL5) mode field readback
            rd_byte = `BWSRC_MODECAP_FIXED | {5'h00, mode_pin_ff};
         end
      end
   end

   // wait state of a read: set by its address phase, gone one cycle later
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_wait_ff <= 1'b0;
      end else begin
         rd_wait_ff <= addr_phase && !hwrite;
      end
   end

   // read data flop, loaded at the end of the wait state and then held;
   // a write just ahead has already landed, so the read sees it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data_ff <= 8'h00;
      end else if (rd_wait_ff) begin
         rd_data_ff <= rd_byte;
      end
   end

   assign hrdata = {24'h000000, rd_data_ff};

   // (RL7) top lines read one outside modes 3, 4, 6
   assign top_addr_enable = addr_sel_mode(mode_pin_ff) ? bus_release_ff[7:5] : 3'h7;

   assign wait_mode_sel = wait_control_ff[`BWSRC_WAITCTL_MODE_LSB +: 2];
   assign wait_count = wait_control_ff[`BWSRC_WAITCTL_CNT_LSB +: 2];
   assign bus_release_enable = bus_release_ff[`BWSRC_RELCTL_EN_BIT];

   // bus release: granted only between own cycles, kept while requested
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         grant_ff <= 1'b0;
      end else if (grant_ff) begin
         grant_ff <= ext_bus_req;
      end else begin
         // (RL6) release only when enabled
         grant_ff <= bus_release_enable && ext_bus_req && !acc_busy && !acc_req;
      end
   end

   assign ext_bus_grant = grant_ff;

   // own accesses wait while the bus is released; a pending own request wins the tie
   assign acc_ready = !acc_busy && !grant_ff;
   assign seq_start = acc_req && acc_ready;

   // external access cycle sequencer
   bwsrc_cycle_seq u_seq (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .cyc_start(seq_start),
      .cyc_area(acc_area),
      .area_three_state(access_state_ff),
      .area_wait_enable(wait_area_enable_ff),
      .wait_mode_sel(wait_mode_sel),
      .wait_count(wait_count),
      .ext_wait_req(ext_wait_req),
      .cyc_state(acc_state),
      .cyc_busy(acc_busy),
      .cyc_done(acc_done)
   );

endmodule

/* test/bwsrc_checker_assertions.sv */
// bwsrc_checker: port-level assertions on bwsrc_top.
// assumes: bound into bwsrc_top; one clock domain, reset active high.
`timescale 1ns/1ps
`include "bwsrc_cfg.svh"
module bwsrc_checker
   import bwsrc_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input wire logic core_clk, // clock
   input wire logic sys_rst, // reset
   input wire logic hsel, // select
   input wire logic [ADDR_W-1:0] haddr, // address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic hready, // ready
   input wire logic [31:0] hrdata, // read data
   input wire logic [2:0] mode_pin, // mode pins
   input wire logic acc_req, // access request
   input wire logic acc_ready, // access taken
   input wire bwsrc_state_t acc_state, // cycle state
   input wire logic acc_busy, // cycle busy
   input wire logic acc_done, // cycle end
   input wire logic ext_bus_req, // bus request
   input wire logic ext_bus_grant, // bus grant
   input wire logic [2:0] top_addr_enable // top lines
);
   logic rd_req;
   // a read accepted in this address phase
   assign rd_req = hsel && hready && htrans[1] && !hwrite;

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   // read data stands in the cycle after the read wait state
   wait_fixed_a: assert property (
      rd_req && haddr == ADDR_W'({`BWSRC_IDX_WAIT_CONTROL, 2'b00})
      |-> ##2 hrdata[31:4] == 28'hf)
      else $error("wait control upper bits wrong");
   mode_read_a: assert property (
      rd_req && haddr == ADDR_W'({`BWSRC_IDX_MODE_CAPTURE, 2'b00})
      |-> ##2 hrdata == {24'h0, 5'h10, $past(mode_pin, 2)})
      else $error("mode field does not follow pins");
   // pins settle one edge before the bank shows them
   top_line_a: assert property (
      !(mode_pin inside {3'h3, 3'h4, 3'h6}) && $stable(mode_pin) |-> top_addr_enable == 3'h7)
      else $error("top lines not address outputs");
   grant_cause_a: assert property (
      $rose(ext_bus_grant) |-> $past(ext_bus_req) && !$past(acc_busy))
      else $error("grant without request");
   grant_drop_a: assert property (
      ext_bus_grant && !ext_bus_req |=> !ext_bus_grant)
      else $error("grant kept after request dropped");
   busy_refuse_a: assert property (
      acc_busy || ext_bus_grant |-> !acc_ready)
      else $error("access taken while busy or granted");
   take_start_a: assert property (
      acc_req && acc_ready |=> acc_state == BWSRC_S_T1 ##1 acc_state == BWSRC_S_T2)
      else $error("access did not start with two base states");
   done_end_a: assert property (
      acc_done |-> acc_state inside {BWSRC_S_T2, BWSRC_S_T3} ##1 acc_state == BWSRC_S_IDLE)
      else $error("access end state wrong");

   grant_c: cover property (ext_bus_grant);
   tw_c: cover property (acc_state == BWSRC_S_TW);
   two_state_c: cover property (acc_done && acc_state == BWSRC_S_T2);
endmodule

bind bwsrc_top bwsrc_checker #(.ADDR_W(ADDR_W)) bwsrc_checker_inst (
   .core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .mode_pin, .acc_req,
   .acc_ready, .acc_state, .acc_busy, .acc_done, .ext_bus_req, .ext_bus_grant, .top_addr_enable
);

/* test/bwsrc_far_side.sv */
// bwsrc_far_side: external wait device and external bus master.
// assumes: bench sets wait_len and bus_want by non-blocking assignment.
`timescale 1ns/1ps
module bwsrc_far_side
   import bwsrc_pkg::*;
(
   input wire logic core_clk, // clock
   input wire logic sys_rst, // reset
   input wire bwsrc_state_t acc_state, // cycle state
   input wire logic [3:0] wait_len, // wait cycles from T2
   input wire logic bus_want, // bench wants the bus
   output logic ext_wait_req, // wait line
   output logic ext_bus_req // bus request
);
   logic [3:0] wait_cnt_ff;
   logic req_ff;
   // wait from T2
   // loaded at T1 so the line is already high when T2 samples it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wait_cnt_ff <= 4'h0;
      end else if (acc_state == BWSRC_S_T1) begin
         wait_cnt_ff <= wait_len;
      end else if (wait_cnt_ff != 4'h0) begin
         wait_cnt_ff <= wait_cnt_ff - 4'h1;
      end
   end
   assign ext_wait_req = (wait_cnt_ff != 4'h0);
   // level request
   // held until the master is done; never pulsed
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         req_ff <= 1'b0;
      end else begin
         req_ff <= bus_want;
      end
   end
   assign ext_bus_req = req_ff;
endmodule

/* test/bus_wait_state_and_release_ctrl_bench.sv */
// bench for bwsrc_top: register bank, access cycles and bus release.
// assumes: bwsrc_far_side plays the external device and master.
`timescale 1ns/1ps
`include "bwsrc_cfg.svh"
module bus_wait_state_and_release_ctrl_bench;
   import bwsrc_pkg::*;
   logic core_clk, sys_rst, hsel, hwrite, acc_req, bus_want, hreadyout, hresp, acc_ready;
   logic ext_wait_req, acc_busy, acc_done, ext_bus_req, ext_bus_grant;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize, mode_pin, acc_area, top_addr_enable;
   logic [31:0] hwdata, hrdata;
   logic [3:0] wait_len;
   logic [7:0] rd;
   bwsrc_state_t acc_state;
   int error_cnt, check_count;

   bwsrc_top bwsrc_top_inst (.core_clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .mode_pin, .acc_req, .acc_area,
      .acc_ready, .ext_wait_req, .acc_state, .acc_busy, .acc_done, .ext_bus_req, .ext_bus_grant,
      .top_addr_enable);
   bwsrc_far_side bwsrc_far_side_inst (.core_clk, .sys_rst, .acc_state, .wait_len, .bus_want,
      .ext_wait_req, .ext_bus_req);

   // free-running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic stall(input string what);
      error_cnt++;
      $display("FAIL %0t timeout %s", $time, what);
      print_verdict();
   endtask

   // one phase of a transfer, ended by an edge that sees ready
   task automatic bus_edge();
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) stall("bus");
   endtask

   // single word transfer; read byte lands in rd
   task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge core_clk);
      haddr <= {2'b00, idx, 2'b00};
      hwrite <= wr;
      htrans <= 2'h2;
      bus_edge();
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      bus_edge();
      rd = hrdata[7:0];
   endtask

   // one external access; counts inserted states and checks the final one
   task automatic access(input logic [2:0] area, input logic [7:0] exp_tw, input bwsrc_state_t fin);
      int n;
      logic [7:0] tw;
      n = 0;
      tw = 8'h0;
      @(posedge core_clk);
      acc_req <= 1'b1;
      acc_area <= area;
      do begin
         @(posedge core_clk);
         n++;
      end while (acc_ready !== 1'b1 && n < 20);
      acc_req <= 1'b0;
      #1;
      while (acc_done !== 1'b1 && n < 40) begin
         if (acc_state === BWSRC_S_TW) tw++;
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n >= 40) stall("access");
      check(tw, exp_tw, "wait states");
      check({5'h0, acc_state}, {5'h0, fin}, "end state");
      check({7'h0, acc_busy}, 8'h01, "busy at end");
   endtask

   task automatic t_reset();
      ahb(1'b0, `BWSRC_IDX_WAIT_CONTROL, 8'h00);
      check(rd, 8'hf3, "wait control reset");
      ahb(1'b0, `BWSRC_IDX_WAIT_AREA_EN, 8'h00);
      check(rd, 8'hff, "area enable reset");
      ahb(1'b0, `BWSRC_IDX_BUS_RELEASE, 8'h00);
      check(rd, 8'hfe, "release reset");
      check({5'h0, top_addr_enable}, 8'h07, "top lines reset");
      ahb(1'b0, 8'hf8, 8'h00);
      check(rd, 8'h00, "unmapped read");
      check({7'h0, hresp}, 8'h00, "okay response");
   endtask

   task automatic t_mode();
      logic [7:0] exp;
      for (int m = 0; m < 8; m++) begin
         @(posedge core_clk);
         mode_pin <= m[2:0];
         ahb(1'b1, `BWSRC_IDX_MODE_CAPTURE, 8'h07);
         ahb(1'b1, `BWSRC_IDX_BUS_RELEASE, {m[2:0], 5'h00});
         ahb(1'b0, `BWSRC_IDX_MODE_CAPTURE, 8'h00);
         check(rd, {5'h10, m[2:0]}, "mode field");
         exp = (m == 3 || m == 4 || m == 6) ? {m[2:0], 5'h1e} : 8'hfe;
         ahb(1'b0, `BWSRC_IDX_BUS_RELEASE, 8'h00);
         check(rd, exp, "release register");
         check({5'h0, top_addr_enable}, {5'h0, exp[7:5]}, "top lines");
      end
      // the mode 7 write must have left the lines stored in mode 6
      @(posedge core_clk);
      mode_pin <= 3'h3;
      ahb(1'b0, `BWSRC_IDX_BUS_RELEASE, 8'h00);
      check(rd, 8'hde, "write refused");
   endtask

   task automatic t_wait();
      for (int c = 0; c < 4; c++) begin
         for (int w = 0; w < 4; w++) begin
            ahb(1'b1, `BWSRC_IDX_WAIT_CONTROL, {4'h0, w[1:0], c[1:0]});
            access(3'h2, (w == 0 || w == 2) ? 8'(c) : 8'h0, BWSRC_S_T3);
            // pin modes with the wait line held for two cycles from T2
            if (w >= 2) begin
               wait_len <= 4'h2;
               access(3'h2, (w == 2 && c < 2) ? 8'h02 : 8'(c), BWSRC_S_T3);
               wait_len <= 4'h0;
            end
         end
      end
      wait_len <= 4'h2;
      ahb(1'b1, `BWSRC_IDX_WAIT_AREA_EN, 8'hfb);
      access(3'h2, 8'h02, BWSRC_S_T3);
      ahb(1'b1, `BWSRC_IDX_WAIT_AREA_EN, 8'hff);
      ahb(1'b1, `BWSRC_IDX_ACCESS_STATE, 8'hfb);
      access(3'h2, 8'h00, BWSRC_S_T2);
      access(3'h5, 8'h03, BWSRC_S_T3);
      wait_len <= 4'h0;
   endtask

   task automatic t_release();
      int n;
      ahb(1'b1, `BWSRC_IDX_BUS_RELEASE, 8'h00);
      bus_want <= 1'b1;
      repeat (8) @(posedge core_clk);
      check({7'h0, ext_bus_grant}, 8'h00, "release refused");
      ahb(1'b1, `BWSRC_IDX_BUS_RELEASE, 8'h01);
      n = 0;
      while (ext_bus_grant !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20) stall("grant");
      #1;
      check({7'h0, acc_ready}, 8'h00, "own access held off");
      bus_want <= 1'b0;
      n = 0;
      while (ext_bus_grant !== 1'b0 && n < 20) begin
         @(posedge core_clk);
         n++;
      end
      if (n >= 20) stall("release");
      check({7'h0, ext_bus_grant}, 8'h00, "bus taken back");
   endtask

   // reset for five cycles, then the scenarios in turn
   initial begin
      sys_rst = 1'b1;
      {hsel, hwrite, acc_req, bus_want, haddr, htrans, hwdata, acc_area} = '0;
      hsize = 3'h2;
      mode_pin = 3'h1;
      wait_len = 4'h0;
      error_cnt = 0;
      check_count = 0;
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      hsel <= 1'b1;
      t_reset();
      t_mode();
      t_wait();
      t_release();
      print_verdict();
   end
endmodule
